// ---- include/mw3_pkg.sv ----
// How it works
// - Bits 31:12 hold a writable translated base used for downstream window three.
// - Translated-base bits enabled by the size mask, and bit 31 always, replace address bits.
// - Type selector bit 0 reads zero in both setup registers; writes ignored.
// - Bits 2:1 hold address type: 00 is 32-bit, 01 is 64-bit.
// - Upstream address type resets to 01, downstream address type to 00.
// - Each size-mask bit makes its base-address bit writable; downstream mask 30:12.
// - Upstream size mask 31:12 is software writable and resets to zero.
// - Downstream setup bit 31 enables the window base register; resets zero.
// - Upper setup bit 31 enables the 64-bit base register; resets zero.
// - Upper setup bits 30:0 are a writable mask for upper base bits.
package mw3_pkg;

    // Register bus geometry.
    localparam int unsigned MW3_AW = 8;
    localparam int unsigned MW3_DW = 32;

    // Register offsets (byte addresses).
    localparam logic [7:0] MW3_OFS_DN_XLAT = 8'h10;
    localparam logic [7:0] MW3_OFS_DN_SETUP = 8'h14;
    localparam logic [7:0] MW3_OFS_DN_UPPER = 8'h18;
    localparam logic [7:0] MW3_OFS_UP_SETUP = 8'h34;
    localparam logic [7:0] MW3_OFS_UP_UPPER = 8'h38;

    // Field positions.
    localparam int unsigned MW3_TYPE_BIT = 0;
    localparam int unsigned MW3_ATYPE_LSB = 1;
    localparam int unsigned MW3_PREF_BIT = 3;
    localparam int unsigned MW3_BASE_LSB = 12;
    localparam int unsigned MW3_EN_BIT = 31;

    // Address type encodings.
    localparam logic [1:0] MW3_ATYPE_32 = 2'h0;
    localparam logic [1:0] MW3_ATYPE_64 = 2'h1;

    // Reset values.
    localparam logic [19:0] MW3_XLAT_RST = 20'h00000;
    localparam logic [1:0] MW3_DN_ATYPE_RST = MW3_ATYPE_32;
    localparam logic [1:0] MW3_UP_ATYPE_RST = MW3_ATYPE_64;
    localparam logic MW3_PREF_RST = 1'h0;
    localparam logic MW3_EN_RST = 1'h0;
    localparam logic [18:0] MW3_DN_SIZE_RST = 19'h00000;
    localparam logic [19:0] MW3_UP_SIZE_RST = 20'h00000;
    localparam logic [30:0] MW3_HI_SIZE_RST = 31'h00000000;
    localparam logic [31:0] MW3_RD_IDLE = 32'h00000000;

    // Register bus request from the software master.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } mw3_req_t;

    // Window configuration handed to the base-address and decode logic.
    typedef struct packed {
        logic en;
        logic hi_en;
        logic pref;
        logic [1:0] atype;
        logic [31:0] lo_wmask;
        logic [30:0] hi_wmask;
    } mw3_win_t;

endpackage

// ---- hdl/mw3_window_setup_regs.sv ----
`timescale 1ns/1ps
module mw3_window_setup_regs
    import mw3_pkg::*;
(
    input wire logic mclk_i,                 // Core clock, 20 MHz.
    input wire logic rstn_i,                 // Asynchronous reset, active low.
    input wire mw3_req_t req_i,              // Register bus request.
    output logic [31:0] rdata_o,             // Read data, one cycle later.
    input wire logic ws_we_i,                // Strap write of downstream setup.
    input wire logic [31:0] ws_data_i,       // Strap value for downstream setup.
    input wire logic dn_req_i,               // Downstream address to translate.
    input wire logic [31:0] dn_addr_i,       // Initiator address in the window.
    output logic dn_valid_o,                 // Translated address is valid.
    output logic [31:0] dn_addr_o,           // Translated downstream address.
    output mw3_win_t dn_win_o,               // Downstream window configuration.
    output mw3_win_t up_win_o                // Upstream window configuration.
);

    // Writable translated base, bits 31:12 of its register.
    logic [19:0] xlat_q;

    // Downstream setup fields, loaded only through the strap path.
    logic [1:0] dn_atype_q;
    logic dn_pref_q;
    logic [18:0] dn_size_q;
    logic dn_en_q;

    // Downstream upper setup fields.
    logic [30:0] dn_hi_size_q;
    logic dn_hi_en_q;

    // Upstream setup fields.
    logic up_pref_q;
    logic [19:0] up_size_q;

    // Upstream upper setup fields.
    logic [30:0] up_hi_size_q;
    logic up_hi_en_q;

    // Bus side registers.
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Translation path registers.
    logic dn_valid_q;
    logic [31:0] dn_addr_q;

    // Decoded write strobes.
    logic wr_xlat;
    logic wr_dn_hi;
    logic wr_up;
    logic wr_up_hi;

    // Packs the low setup word; the type selector always reads as memory.
    function automatic logic [31:0] setup_word(
        input logic [1:0] atype,
        input logic pref,
        input logic [19:0] size,
        input logic en
    );
        logic [31:0] w;
        w = 32'h00000000;
        w[MW3_TYPE_BIT] = 1'b0;
        w[MW3_ATYPE_LSB +: 2] = atype;
        w[MW3_PREF_BIT] = pref;
        w[31:MW3_BASE_LSB] = size;
        if (en) begin
            w[MW3_EN_BIT] = 1'b1;
        end
        return w;
    endfunction

    // Packs an upper setup word from its mask and its enable.
    function automatic logic [31:0] upper_word(
        input logic [30:0] size,
        input logic en
    );
        return {en, size};
    endfunction

    // Expands a size field to a full write mask for the low base register.
    function automatic logic [31:0] low_mask(input logic [19:0] size);
        return {size, 12'h000};
    endfunction

    // Merges translated base bits under the mask with the original offset.
    function automatic logic [31:0] xlat_merge(
        input logic [31:0] base,
        input logic [31:0] addr,
        input logic [31:0] mask
    );
        return (base & mask) | (addr & ~mask);
    endfunction

    // Address decode for bus writes; the downstream setup has no bus write.
    assign wr_xlat = req_i.we && (req_i.addr == MW3_OFS_DN_XLAT);
    assign wr_dn_hi = req_i.we && (req_i.addr == MW3_OFS_DN_UPPER);
    assign wr_up = req_i.we && (req_i.addr == MW3_OFS_UP_SETUP);
    assign wr_up_hi = req_i.we && (req_i.addr == MW3_OFS_UP_UPPER);

    // Translated base; the low twelve bits are never stored.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xlat_q <= MW3_XLAT_RST;
        end else if (wr_xlat) begin
            xlat_q <= req_i.wdata[31:MW3_BASE_LSB];
        end
    end

    // Downstream setup is read-only to software; only the strap loads it.
    // Bit 31 of the strap word lands in the enable, not in the size mask.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dn_atype_q <= MW3_DN_ATYPE_RST;
            dn_pref_q <= MW3_PREF_RST;
            dn_size_q <= MW3_DN_SIZE_RST;
            dn_en_q <= MW3_EN_RST;
        end else if (ws_we_i) begin
            dn_atype_q <= ws_data_i[MW3_ATYPE_LSB +: 2];
            dn_pref_q <= ws_data_i[MW3_PREF_BIT];
            dn_size_q <= ws_data_i[30:MW3_BASE_LSB];
            dn_en_q <= ws_data_i[MW3_EN_BIT];
        end
    end

    // Downstream upper setup, fully writable by software.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dn_hi_size_q <= MW3_HI_SIZE_RST;
            dn_hi_en_q <= MW3_EN_RST;
        end else if (wr_dn_hi) begin
            dn_hi_size_q <= req_i.wdata[30:0];
            dn_hi_en_q <= req_i.wdata[MW3_EN_BIT];
        end
    end

    // Upstream setup; its address type is fixed and takes no write.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_pref_q <= MW3_PREF_RST;
            up_size_q <= MW3_UP_SIZE_RST;
        end else if (wr_up) begin
            up_pref_q <= req_i.wdata[MW3_PREF_BIT];
            up_size_q <= req_i.wdata[31:MW3_BASE_LSB];
        end
    end

    // Upstream upper setup, fully writable by software.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_hi_size_q <= MW3_HI_SIZE_RST;
            up_hi_en_q <= MW3_EN_RST;
        end else if (wr_up_hi) begin
            up_hi_size_q <= req_i.wdata[30:0];
            up_hi_en_q <= req_i.wdata[MW3_EN_BIT];
        end
    end

    // Read multiplexer; unmapped offsets and reserved fields read zero.
    always_comb begin
        rdata_d = MW3_RD_IDLE;
        unique case (req_i.addr)
            MW3_OFS_DN_XLAT: begin
                rdata_d = {xlat_q, 12'h000};
            end
            MW3_OFS_DN_SETUP: begin
                rdata_d = setup_word(dn_atype_q, dn_pref_q,
                    {1'b0, dn_size_q}, dn_en_q);
            end
            MW3_OFS_DN_UPPER: begin
                rdata_d = upper_word(dn_hi_size_q, dn_hi_en_q);
            end
            MW3_OFS_UP_SETUP: begin
                rdata_d = setup_word(MW3_UP_ATYPE_RST, up_pref_q,
                    up_size_q, 1'b0);
            end
            MW3_OFS_UP_UPPER: begin
                rdata_d = upper_word(up_hi_size_q, up_hi_en_q);
            end
            default: begin
                rdata_d = MW3_RD_IDLE;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= MW3_RD_IDLE;
        end else if (req_i.re) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= MW3_RD_IDLE;
        end
    end

    // Downstream translation. Bit 31 is always base, since the downstream
    // mask stops at bit 30; requests while disabled are dropped so that a
    // half-programmed window never forwards a bogus address.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dn_valid_q <= 1'b0;
            dn_addr_q <= 32'h00000000;
        end else begin
            dn_valid_q <= dn_req_i && dn_en_q;
            if (dn_req_i && dn_en_q) begin
                dn_addr_q <= xlat_merge({xlat_q, 12'h000}, dn_addr_i,
                    low_mask({1'b1, dn_size_q}));
            end
        end
    end

    // Outputs come straight from the registers above.
    assign rdata_o = rdata_q;
    assign dn_valid_o = dn_valid_q;
    assign dn_addr_o = dn_addr_q;

    // Window configuration and write masks for the base-address logic that lives outside.
    assign dn_win_o.en = dn_en_q;
    assign dn_win_o.hi_en = dn_hi_en_q;
    assign dn_win_o.pref = dn_pref_q;
    assign dn_win_o.atype = dn_atype_q;
    assign dn_win_o.lo_wmask = low_mask({1'b0, dn_size_q});
    assign dn_win_o.hi_wmask = dn_hi_size_q;

    // The upstream setup has no enable bit; the window counts as enabled.
    assign up_win_o.en = 1'b1;
    assign up_win_o.hi_en = up_hi_en_q;
    assign up_win_o.pref = up_pref_q;
    assign up_win_o.atype = MW3_UP_ATYPE_RST;
    assign up_win_o.lo_wmask = low_mask(up_size_q);
    assign up_win_o.hi_wmask = up_hi_size_q;

endmodule // mw3_window_setup_regs

// ---- bench/mw3_window_setup_regs_asserts.sv ----
`timescale 1ns/1ps
// Port-level checks of the window setup register bank.
module mw3_window_setup_regs_asserts
    import mw3_pkg::*;
(
    input wire logic mclk_i,           // Core clock.
    input wire logic rstn_i,           // Reset, active low.
    input wire mw3_req_t req_i,        // Register bus request.
    input wire logic [31:0] rdata_o,   // Read data.
    input wire logic ws_we_i,          // Strap strobe.
    input wire logic [31:0] ws_data_i, // Strap word.
    input wire logic dn_req_i,         // Translation request.
    input wire logic [31:0] dn_addr_i, // Address to translate.
    input wire logic dn_valid_o,       // Translation valid.
    input wire logic [31:0] dn_addr_o, // Translated address.
    input wire mw3_win_t dn_win_o,     // Downstream configuration.
    input wire mw3_win_t up_win_o      // Upstream configuration.
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic rd_q;
    logic [7:0] ra_q;
    // Track the last read so returned data can be tied to its address.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_q <= 1'b0;
            ra_q <= 8'h00;
        end else begin
            rd_q <= req_i.re;
            ra_q <= req_i.addr;
        end
    end
    a_rdata_idle: assert property (!rd_q |-> rdata_o == 32'h0)
        else $error("read data not idle");
    a_xlat_low: assert property (rd_q && ra_q == 8'h10 |->
        rdata_o[11:0] == 12'h000) else $error("translated base low bits");
    a_type_zero: assert property (rd_q && (ra_q == 8'h14 ||
        ra_q == 8'h34) |-> rdata_o[0] == 1'b0 && rdata_o[11:4] == 8'h00)
        else $error("setup fixed bits");
    a_up_atype: assert property (rd_q && ra_q == 8'h34 |->
        rdata_o[2:1] == 2'h1 && up_win_o.atype == 2'h1)
        else $error("upstream address type");
    a_dn_fields: assert property (rd_q && ra_q == 8'h14 |->
        rdata_o[31:12] == {$past(dn_win_o.en), $past(dn_win_o.lo_wmask[30:12])})
        else $error("downstream setup readback");
    a_up_fields: assert property (rd_q && ra_q == 8'h34 |->
        rdata_o[31:12] == $past(up_win_o.lo_wmask[31:12]) &&
        rdata_o[3] == $past(up_win_o.pref)) else $error("upstream readback");
    a_hi_fields: assert property (rd_q && ra_q == 8'h38 |->
        rdata_o == {$past(up_win_o.hi_en), $past(up_win_o.hi_wmask)})
        else $error("upstream upper readback");
    a_strap_load: assert property (ws_we_i |=>
        dn_win_o.en == $past(ws_data_i[31]) &&
        dn_win_o.lo_wmask[30:12] == $past(ws_data_i[30:12]))
        else $error("strap not loaded");
    a_dn_accept: assert property (dn_req_i && dn_win_o.en |=> dn_valid_o)
        else $error("translation missed");
    a_dn_refuse: assert property (!(dn_req_i && dn_win_o.en) |=>
        !dn_valid_o) else $error("translation while disabled");
    // Bits outside the size mask, except bit 31, must pass through from the request.
    a_xlat_pass: assert property (dn_valid_o |->
        ((dn_addr_o ^ $past(dn_addr_i)) &
        ~{1'b1, $past(dn_win_o.lo_wmask[30:0])}) == 32'h0)
        else $error("untranslated bits changed");
    c_read: cover property (rd_q && ra_q == 8'h34);
    c_strap: cover property (ws_we_i && ws_data_i[31]);
    c_xlat: cover property (dn_valid_o);
endmodule // mw3_window_setup_regs_asserts

// ---- bench/mw3_window_setup_regs_tb.sv ----
`timescale 1ns/1ps
module mw3_window_setup_regs_tb
    import mw3_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    mw3_req_t req_i = '0;
    logic ws_we_i = 1'b0;
    logic [31:0] ws_data_i = 32'h0;
    logic dn_req_i = 1'b0;
    logic [31:0] dn_addr_i = 32'h0;
    logic [31:0] rdata_o;
    logic [31:0] dn_addr_o;
    logic dn_valid_o;
    mw3_win_t dn_win_o;
    mw3_win_t up_win_o;
    int n_errors = 0;
    int compares = 0;
    mw3_window_setup_regs u_dut (.mclk_i, .rstn_i, .req_i, .rdata_o,
        .ws_we_i, .ws_data_i, .dn_req_i, .dn_addr_i, .dn_valid_o,
        .dn_addr_o, .dn_win_o, .up_win_o);
    // Clock at 20 MHz and a reset of twelve cycles.
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        rstn_i <= 1'b1;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        req_i <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk_i);
        req_i.we <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        req_i <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk_i);
        req_i.re <= 1'b0;
        #1 check(rdata_o, exp);
    endtask
    task automatic strap(input logic [31:0] d);
        @(posedge mclk_i);
        ws_we_i <= 1'b1;
        ws_data_i <= d;
        @(posedge mclk_i);
        ws_we_i <= 1'b0;
    endtask
    task automatic xl(input logic [31:0] a, input logic v,
        input logic [31:0] exp);
        @(posedge mclk_i);
        dn_req_i <= 1'b1;
        dn_addr_i <= a;
        @(posedge mclk_i);
        dn_req_i <= 1'b0;
        #1 check({31'h0, dn_valid_o}, {31'h0, v});
        if (v) check(dn_addr_o, exp);
        @(posedge mclk_i);
        #1 check({31'h0, dn_valid_o}, 32'h0);
    endtask
    task automatic t_reset;
        rdchk(8'h10, 32'h0);
        rdchk(8'h14, 32'h0);
        rdchk(8'h18, 32'h0);
        rdchk(8'h34, 32'h00000002);
        rdchk(8'h38, 32'h0);
        rdchk(8'h20, 32'h0);
    endtask
    task automatic t_regs;
        wr(8'h10, 32'hFFFFFFFF);
        rdchk(8'h10, 32'hFFFFF000);
        wr(8'h14, 32'hFFFFFFFF);
        rdchk(8'h14, 32'h0);
        wr(8'h34, 32'hFFFFFFFF);
        rdchk(8'h34, 32'hFFFFF00A);
        wr(8'h34, 32'h0);
        rdchk(8'h34, 32'h00000002);
        wr(8'h38, 32'hFFFFFFFF);
        rdchk(8'h38, 32'hFFFFFFFF);
        wr(8'h18, 32'h80000001);
        rdchk(8'h18, 32'h80000001);
    endtask
    // Top address bit comes from the base, masked bits too, the rest pass.
    task automatic t_xlat;
        check({27'h0, up_win_o.en, up_win_o.hi_en, up_win_o.pref,
            up_win_o.atype}, 32'h00000019);
        check({1'b0, up_win_o.hi_wmask}, 32'h7FFFFFFF);
        strap(32'h8000F00A);
        rdchk(8'h14, 32'h8000F00A);
        check({27'h0, dn_win_o.en, dn_win_o.hi_en, dn_win_o.pref,
            dn_win_o.atype}, 32'h0000001D);
        check({1'b0, dn_win_o.hi_wmask}, 32'h00000001);
        check(dn_win_o.lo_wmask, 32'h0000F000);
        wr(8'h10, 32'h12345000);
        xl(32'h8ABCDEF0, 1'b1, 32'h0ABC5EF0);
        strap(32'h0000F002);
        rdchk(8'h14, 32'h0000F002);
        xl(32'h8ABCDEF0, 1'b0, 32'h0);
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        @(posedge rstn_i);
        t_reset;
        t_regs;
        t_xlat;
        conclude;
    end
    // The tests take about fifty cycles after reset; a hang is cut off well after.
    initial begin
        repeat (2000) @(posedge mclk_i);
        n_errors++;
        conclude;
    end
endmodule // mw3_window_setup_regs_tb
bind mw3_window_setup_regs mw3_window_setup_regs_asserts u_chk (.mclk_i,
    .rstn_i, .req_i, .rdata_o, .ws_we_i, .ws_data_i, .dn_req_i, .dn_addr_i,
    .dn_valid_o, .dn_addr_o, .dn_win_o, .up_win_o);
